// ### clsc_params.svh
/*
  Constants for the closed-loop stop configuration register bank.
  Assumes a 32-bit AXI4-Lite register bus and a 125 MHz clock.
*/
`ifndef CLSC_PARAMS_SVH
`define CLSC_PARAMS_SVH

// Registers are word indices; the bus byte address is four times the index.
`define CLSC_ADDR_W          10
`define CLSC_IDX_LOOP_FB     8'h88
`define CLSC_IDX_STOP_CFG    8'h8A
`define CLSC_OFF_LOOP_FB     ({`CLSC_IDX_LOOP_FB, 2'h0})
`define CLSC_OFF_STOP_CFG    ({`CLSC_IDX_STOP_CFG, 2'h0})
// Field positions inside the loop feedback word.
`define CLSC_LB_PULSE_POLICY 7
`define CLSC_LB_THR_HI       6
`define CLSC_LB_THR_LO       4
`define CLSC_LB_SURGE        3
`define CLSC_LB_DEADTIME     2
`define CLSC_LB_RSVD         1
`define CLSC_LB_EARLY_STOP   0
`define CLSC_RST_STOP_CFG    32'h00000000
`define CLSC_RST_LOOP_FB     32'h00000000
`define CLSC_LOOP_FB_WMASK   32'hFFFFFFFD
`define CLSC_RESP_OKAY       2'h0
`define CLSC_RESP_SLVERR     2'h2
`define CLSC_THR_LAST        3'h5
`define CLSC_STOP_LAST       3'h4
`define CLSC_CLK_MHZ         125
`define CLSC_MS_CYCLES       (`CLSC_CLK_MHZ * 1000)

`endif

// ### clsc_pkg.sv
/*
  Types for the closed-loop stop configuration register bank.
  Assumes the constants of clsc_params.svh.
*/
package clsc_pkg;

  // Stop methods as encoded in the stop_method field.
  typedef enum logic [2:0] {
    CLSC_STOP_HIZ,
    CLSC_STOP_RECIRC,
    CLSC_STOP_LOW_BRAKE,
    CLSC_STOP_HIGH_BRAKE,
    CLSC_STOP_SPIN_DOWN
  } clsc_stop_e;

  // Gate drive request to the power stage, one bit per phase in high_on and low_on.
  typedef struct packed {
    logic [2:0] high_on;
    logic [2:0] low_on;
    logic       hiz;
    logic       spin_down;
  } clsc_drive_s;

  // Stop and motor parameter word.
  typedef struct packed {
    logic       parity;
    logic [2:0] stop_method;
    logic [3:0] brake_hold_time;
    logic [3:0] spin_down_speed_threshold;
    logic [3:0] brake_speed_threshold;
    logic [7:0] winding_resistance;
    logic [7:0] winding_inductance;
  } clsc_stop_cfg_s;

endpackage : clsc_pkg

// ### clsc_regs.sv
/*
  Closed-loop stop configuration registers on AXI4-Lite, and the stop
  drive decode they steer.
  Assumes one synchronous clock aclk and a synchronous active-low reset.
*/
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "clsc_params.svh"

// Notes on behaviour
// - Bits 6..4 pick speed-pulse EMF threshold; codes 0..5 valid, 6,7 unused.
// - Threshold stop policy keeps speed pulse until EMF falls below it.
// - Bit 0 picks hi-z or low-side brake for recirculation in early states.
// - Stop and motor parameter word sits at offset 8Ah, resets to zero.
// - Bits 30..28 pick stop method; 0 hi-z, 1 recirculation, 5..7 unused.
// - Stop method 2 turns on all three low-side switches.
// - Stop method 3 turns on all three high-side switches.
// - Stop method 4 decelerates actively by controlled drive.
// - Four-bit brake hold time; codes 0..4 are 1 ms, up to 15000 ms.
// - Four-bit spin-down threshold, percent of max speed, 100 down to 2.5.
module clsc_regs (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [9:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [9:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   stop_request,
  input  wire logic                   motor_early_state,
  input  wire logic                   motor_driven,
  input  wire logic                   emf_below_threshold,
  output logic                        speed_pulse_enable,
  output clsc_pkg::clsc_drive_s       stage_drive,
  output logic [2:0]                  speed_pulse_emf_threshold,
  output logic [3:0]                  brake_hold_time,
  output logic [3:0]                  spin_down_speed_threshold,
  output logic [3:0]                  brake_speed_threshold,
  output logic [7:0]                  winding_resistance,
  output logic [7:0]                  winding_inductance,
  output logic                        surge_guard_enable,
  output logic                        deadtime_comp_enable
);

  // Register state and bus channel state.
  logic [31:0]               loop_fb_q, loop_fb_d;
  clsc_pkg::clsc_stop_cfg_s  stop_cfg_q, stop_cfg_d;
  logic [9:0]                awaddr_q, awaddr_d;
  logic                      aw_held_q, aw_held_d;
  logic [31:0]               wdata_q, wdata_d;
  logic [3:0]                wstrb_q, wstrb_d;
  logic                      w_held_q, w_held_d;
  logic                      bvalid_q, bvalid_d;
  logic [1:0]                bresp_q, bresp_d;
  logic                      rvalid_q, rvalid_d;
  logic [1:0]                rresp_q, rresp_d;
  logic [31:0]               rdata_q, rdata_d;
  logic                      pulse_q, pulse_d;
  clsc_pkg::clsc_drive_s     drive_q, drive_d;
  logic [31:0]               wmerge;
  logic                      do_write;

  // Address and data are each held once taken, so either order works.
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign do_write      = aw_held_q && w_held_q && !bvalid_q;

  // Byte-lane merge of the held write data into the addressed word.
  always_comb begin
    logic [31:0] cur;
    cur = (awaddr_q == `CLSC_OFF_STOP_CFG) ? stop_cfg_q : loop_fb_q;
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = wstrb_q[b] ? wdata_q[b*8 +: 8] : cur[b*8 +: 8];
    end
  end

  // Next state of the bus channels and the two configuration words.
  always_comb begin
    awaddr_d   = awaddr_q;
    aw_held_d  = aw_held_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    w_held_d   = w_held_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    loop_fb_d  = loop_fb_q;
    stop_cfg_d = stop_cfg_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_d  = s_axi_awaddr;
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      w_held_d = 1'b1;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `CLSC_RESP_OKAY;
      if (awaddr_q == `CLSC_OFF_STOP_CFG) begin
        stop_cfg_d = wmerge;
      end else if (awaddr_q == `CLSC_OFF_LOOP_FB) begin
        loop_fb_d = wmerge & `CLSC_LOOP_FB_WMASK;
      end else begin
        bresp_d = `CLSC_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `CLSC_RESP_OKAY;
      if (s_axi_araddr == `CLSC_OFF_STOP_CFG) begin
        rdata_d = stop_cfg_q;
      end else if (s_axi_araddr == `CLSC_OFF_LOOP_FB) begin
        rdata_d = loop_fb_q;
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = `CLSC_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // Stop drive decode; unused method codes fall back to hi-z as the
  // safest state for the bridge.
  always_comb begin
    drive_d = '0;
    pulse_d = motor_driven;
    if (stop_request) begin
      case (clsc_pkg::clsc_stop_e'(stop_cfg_q.stop_method))
        clsc_pkg::CLSC_STOP_RECIRC: begin
          if (motor_early_state && loop_fb_q[`CLSC_LB_EARLY_STOP]) begin
            drive_d.low_on = 3'h7;
          end else begin
            drive_d.hiz = 1'b1;
          end
        end
        clsc_pkg::CLSC_STOP_LOW_BRAKE: drive_d.low_on = 3'h7;
        clsc_pkg::CLSC_STOP_HIGH_BRAKE: drive_d.high_on = 3'h7;
        clsc_pkg::CLSC_STOP_SPIN_DOWN: drive_d.spin_down = 1'b1;
        default: drive_d.hiz = 1'b1;
      endcase
    end
    // With the stop-at-threshold policy the pulse outlives the drive.
    if (loop_fb_q[`CLSC_LB_PULSE_POLICY]) begin
      pulse_d = (motor_driven || pulse_q) && !emf_below_threshold;
    end
  end

  // Registers; everything resets to zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_fb_q  <= `CLSC_RST_LOOP_FB;
      stop_cfg_q <= `CLSC_RST_STOP_CFG;
      awaddr_q   <= 10'h000;
      aw_held_q  <= 1'b0;
      wdata_q    <= 32'h00000000;
      wstrb_q    <= 4'h0;
      w_held_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= 2'h0;
      rvalid_q   <= 1'b0;
      rresp_q    <= 2'h0;
      rdata_q    <= 32'h00000000;
      pulse_q    <= 1'b0;
      drive_q    <= '0;
    end else begin
      loop_fb_q  <= loop_fb_d;
      stop_cfg_q <= stop_cfg_d;
      awaddr_q   <= awaddr_d;
      aw_held_q  <= aw_held_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      w_held_q   <= w_held_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
      pulse_q    <= pulse_d;
      drive_q    <= drive_d;
    end
  end

  // Field outputs straight from the register flops.
  assign speed_pulse_emf_threshold =
    loop_fb_q[`CLSC_LB_THR_HI:`CLSC_LB_THR_LO];
  assign surge_guard_enable        = loop_fb_q[`CLSC_LB_SURGE];
  assign deadtime_comp_enable      = loop_fb_q[`CLSC_LB_DEADTIME];
  assign brake_hold_time           = stop_cfg_q.brake_hold_time;
  assign spin_down_speed_threshold = stop_cfg_q.spin_down_speed_threshold;
  assign brake_speed_threshold     = stop_cfg_q.brake_speed_threshold;
  assign winding_resistance        = stop_cfg_q.winding_resistance;
  assign winding_inductance        = stop_cfg_q.winding_inductance;
  assign speed_pulse_enable        = pulse_q;
  assign stage_drive               = drive_q;

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn) loop_fb_q[`CLSC_LB_RSVD] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved bit of loop word is set.");

  property p_low_brake;
    @(posedge aclk) disable iff (!aresetn)
      (stop_request && stop_cfg_q.stop_method == 3'h2)
      |=> stage_drive.low_on == 3'h7 && stage_drive.high_on == 3'h0;
  endproperty
  a_low_brake: assert property (p_low_brake)
    else $error("Low-side brake not applied.");

  property p_high_brake;
    @(posedge aclk) disable iff (!aresetn)
      (stop_request && stop_cfg_q.stop_method == 3'h3)
      |=> stage_drive.high_on == 3'h7 && stage_drive.low_on == 3'h0;
  endproperty
  a_high_brake: assert property (p_high_brake)
    else $error("High-side brake not applied.");

  property p_spin_down;
    @(posedge aclk) disable iff (!aresetn)
      (stop_request && stop_cfg_q.stop_method == 3'h4)
      |=> stage_drive.spin_down && !stage_drive.hiz;
  endproperty
  a_spin_down: assert property (p_spin_down)
    else $error("Active spin down not requested.");

  property p_hiz;
    @(posedge aclk) disable iff (!aresetn)
      (stop_request && (stop_cfg_q.stop_method == 3'h0 ||
       stop_cfg_q.stop_method > `CLSC_STOP_LAST)) |=> stage_drive.hiz;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("Hi-z stop not applied.");

  property p_recirc_early;
    @(posedge aclk) disable iff (!aresetn)
      (stop_request && stop_cfg_q.stop_method == 3'h1 && motor_early_state)
      |=> (stage_drive.low_on == 3'h7) ==
          $past(loop_fb_q[`CLSC_LB_EARLY_STOP]);
  endproperty
  a_recirc_early: assert property (p_recirc_early)
    else $error("Early-state recirculation stop wrong.");

  property p_pulse_stop;
    @(posedge aclk) disable iff (!aresetn)
      (loop_fb_q[`CLSC_LB_PULSE_POLICY] && emf_below_threshold)
      |=> !speed_pulse_enable;
  endproperty
  a_pulse_stop: assert property (p_pulse_stop)
    else $error("Speed pulse kept below threshold.");

  property p_readback;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == `CLSC_OFF_STOP_CFG)
      |=> s_axi_rvalid && s_axi_rdata == $past(stop_cfg_q);
  endproperty
  a_readback: assert property (p_readback)
    else $error("Read data does not match stop word.");

  property p_write_resp;
    @(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("Write response missing.");

endmodule // clsc_regs

// ### clsc_stage_model.sv
/*
  Behavioural three-phase power stage and motor for the stop bench.
  Assumes stage_drive and the threshold code come from clsc_regs on aclk.
*/
`timescale 1ns/1ps
module clsc_stage_model #(
  parameter int DECAY = 1
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  spin,
  input  wire logic [2:0]            thr,
  input  wire clsc_pkg::clsc_drive_s drive,
  output logic                       emf_below
);
  logic [5:0] speed_q;
  logic [5:0] speed_d;

  // Speed jumps while driven and coasts down slowly, so a stop waits.
  always_comb begin
    speed_d = speed_q;
    if (spin) begin
      speed_d = 6'h14;
    end else if (|drive.low_on || |drive.high_on) begin
      // A brake on either side stops the rotor at once in this model.
      speed_d = 6'h00;
    end else if (speed_q > 6'h00) begin
      speed_d = speed_q - 6'(DECAY);
    end
  end

  always_ff @(posedge aclk) begin
    speed_q <= aresetn ? speed_d : 6'h00;
  end

  // The EMF scales with speed, so a higher code is crossed sooner.
  assign emf_below = (speed_q <= {3'h0, thr});
endmodule // clsc_stage_model

// ### closed_loop_stop_config_regs_test.sv
/*
  Self-checking bench for clsc_regs over AXI4-Lite and the stop drive.
  Assumes clsc_stage_model as the power stage and a 125 MHz aclk.
*/
`timescale 1ns/1ps
`include "clsc_params.svh"
module closed_loop_stop_config_regs_test;
  logic                  aclk, aresetn, awvalid, awready, wvalid, wready;
  logic                  bvalid, bready, arvalid, arready, rvalid, rready;
  logic [9:0]            awaddr, araddr;
  logic [7:0]            res, ind;
  logic [31:0]           wdata, rdata, d;
  logic [3:0]            wstrb, brk_time, spin_thr, brk_thr;
  logic [1:0]            bresp, rresp;
  logic                  stop_req, early, driven, emf, pulse, surge, dt;
  logic [2:0]            thr;
  logic [33:0]           e;
  logic [33:0]           exp_q[$];
  clsc_pkg::clsc_drive_s drive;
  int                    mismatches, cmp_count, n;

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  clsc_regs clsc_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stop_request(stop_req),
    .motor_early_state(early), .motor_driven(driven),
    .emf_below_threshold(emf), .speed_pulse_enable(pulse),
    .stage_drive(drive), .speed_pulse_emf_threshold(thr),
    .brake_hold_time(brk_time), .spin_down_speed_threshold(spin_thr),
    .brake_speed_threshold(brk_thr), .winding_resistance(res),
    .winding_inductance(ind), .surge_guard_enable(surge),
    .deadtime_comp_enable(dt));

  clsc_stage_model clsc_stage_model_inst (.aclk(aclk), .aresetn(aresetn),
    .spin(driven), .thr(thr), .drive(drive), .emf_below(emf));

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One transfer; each channel drops only at the edge that takes it.
  task automatic bus(input logic rd, input logic [9:0] a,
                     input logic [31:0] wd, input logic [33:0] ex);
    int k;
    exp_q.push_back(ex);
    @(posedge aclk);
    if (rd) begin
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    end else begin
      awaddr <= a; awvalid <= 1'b1; wdata <= wd; wvalid <= 1'b1;
      bready <= 1'b1;
    end
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) rready <= 1'b0;
    end while ((awvalid || wvalid || bready || arvalid || rready) && k < 40);
    if (k >= 40) begin
      mismatches++;
      wrap_up();
    end
  endtask

  // The slave only ever answers what was asked, oldest note first.
  always @(posedge aclk) begin
    if (aresetn && ((bvalid && bready) || (rvalid && rready))) begin
      e = exp_q.pop_front();
      chk("resp", {30'h0, bvalid ? bresp : rresp}, {30'h0, e[33:32]});
      if (rvalid) chk("rdata", rdata, e[31:0]);
    end
  end

  function automatic clsc_pkg::clsc_drive_s exp_drv(input logic [2:0] m,
                                                    input logic ea,
                                                    input logic s);
    clsc_pkg::clsc_drive_s x;
    x = '0;
    case (m)
      3'h1: if (ea && s) x.low_on = 3'h7; else x.hiz = 1'b1;
      3'h2: x.low_on = 3'h7;
      3'h3: x.high_on = 3'h7;
      3'h4: x.spin_down = 1'b1;
      default: x.hiz = 1'b1;
    endcase
    return x;
  endfunction

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, stop_req, early, driven} = '0;
    wstrb = 4'hF;
    void'($urandom(32'h83409B2D));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus(1'b1, `CLSC_OFF_STOP_CFG, 32'h0,
        {`CLSC_RESP_OKAY, `CLSC_RST_STOP_CFG});
    bus(1'b1, `CLSC_OFF_LOOP_FB, 32'h0, {`CLSC_RESP_OKAY, `CLSC_RST_LOOP_FB});
    bus(1'b0, 10'h000, 32'h12345678, {`CLSC_RESP_SLVERR, 32'h0});
    bus(1'b1, 10'h000, 32'h0, {`CLSC_RESP_SLVERR, 32'h0});
    bus(1'b0, `CLSC_OFF_LOOP_FB, 32'hFFFFFFFF, {`CLSC_RESP_OKAY, 32'h0});
    bus(1'b1, `CLSC_OFF_LOOP_FB, 32'h0, {`CLSC_RESP_OKAY, 32'hFFFFFFFD});
    chk("loop_out", {27'h0, thr, surge, dt}, 32'h1F);
    // Random stop words, each followed by one valid threshold code, 0 to 5 in turn.
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      bus(1'b0, `CLSC_OFF_STOP_CFG, d, {`CLSC_RESP_OKAY, 32'h0});
      bus(1'b1, `CLSC_OFF_STOP_CFG, 32'h0, {`CLSC_RESP_OKAY, d});
      chk("fields", {4'h0, brk_time, spin_thr, brk_thr, res, ind},
          {4'h0, d[27:0]});
      bus(1'b0, `CLSC_OFF_LOOP_FB, {25'h0, i[2:0], 4'h0}, 34'h0);
      chk("thr", {29'h0, thr}, {29'h0, i[2:0]});
    end
    // Every stop code in both motor states and both early-stop choices.
    stop_req <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      bus(1'b0, `CLSC_OFF_LOOP_FB, {31'h0, s[0]}, 34'h0);
      for (int m = 0; m < 8; m++) begin
        bus(1'b0, `CLSC_OFF_STOP_CFG, {1'b0, m[2:0], 28'h0}, 34'h0);
        for (int ea = 0; ea < 2; ea++) begin
          early <= ea[0];
          repeat (2) @(posedge aclk);
          chk("drive", {24'h0, drive},
              {24'h0, exp_drv(m[2:0], ea[0], s[0])});
        end
      end
    end
    stop_req <= 1'b0;
    // Hold-until-threshold policy with code 2; the model coasts down.
    bus(1'b0, `CLSC_OFF_LOOP_FB, 32'h000000A0, 34'h0);
    driven <= 1'b1;
    repeat (3) @(posedge aclk);
    driven <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("pulse_hold", {31'h0, pulse}, 32'h1);
    n = 0;
    while (pulse === 1'b1 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 60) begin
      mismatches++;
      wrap_up();
    end
    chk("emf_at_drop", {31'h0, emf}, 32'h1);
    // Plain policy follows the drive one clock later.
    bus(1'b0, `CLSC_OFF_LOOP_FB, 32'h0, 34'h0);
    driven <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("pulse_on", {31'h0, pulse}, 32'h1);
    driven <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("pulse_off", {31'h0, pulse}, 32'h0);
    wrap_up();
  end
endmodule // closed_loop_stop_config_regs_test
